// [hdl/csr_regs.sv]
// ----------------------------------------------------------------------------
// converter setpoint registers: step-down three and buck-boost
// ----------------------------------------------------------------------------
// assumes the serial-bus engine delivers one-cycle read and write strobes
// with subaddress and data, and a password unlock level from the lock logic.
`timescale 1ns/100ps
module csr_regs
	import csr_pkg::*;
#(
	parameter int BLANK_CYCLES = CSR_BLANK_CYC
)(
	// clock and reset
	input  wire logic       CLOCK,
	input  wire logic       RSTN,
	// register access from the serial-bus engine
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR_STB,
	input  wire logic       RD_STB,
	input  wire logic       UNLOCKED,
	output logic [7:0]      RDATA,
	output logic            RD_HIT,
	output logic            WR_DONE,
	// strap pin
	input  wire logic       DEFAULT_SELECT_STRAP,
	// converter controls
	output logic            BUCK3_PULSE_SKIP_ENABLE,
	output logic [5:0]      BUCK3_VOLTAGE_CODE,
	output logic            BUCK3_MON_BLANK,
	output logic            BUCKBOOST_PULSE_SKIP_ENABLE,
	output logic [5:0]      BUCKBOOST_VOLTAGE_CODE,
	output logic            BUCKBOOST_MON_BLANK
);
	// ------------------------------------------------------------------------
	// strap synchroniser and power-up load
	// ------------------------------------------------------------------------
	logic strap_meta_ff;
	logic strap_sync_ff;
	logic loaded_ff;

	// two flops before the strap is used
	always_ff @(posedge CLOCK)
	begin
		strap_meta_ff <= DEFAULT_SELECT_STRAP;
		strap_sync_ff <= strap_meta_ff;
	end

	// first cycles after reset: one-shot load of strap defaults
	logic [1:0] settle_ff;
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			settle_ff <= 2'h0;
		else if (settle_ff != 2'h3)
			settle_ff <= settle_ff + 2'h1;
	end
	logic strap_load;
	assign strap_load = (settle_ff == 2'h2) && !loaded_ff;

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			loaded_ff <= 1'b0;
		else if (strap_load)
			loaded_ff <= 1'b1;
	end

	// ------------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	logic sel_b3;
	logic sel_bb;
	logic wr_b3;
	logic wr_bb;
	// writes take effect only when unlocked
	assign sel_b3 = hit(ADDR, CSR_ADDR_BUCK3); // R1
	assign sel_bb = hit(ADDR, CSR_ADDR_BUCKBOOST); // R7
	assign wr_b3  = WR_STB && sel_b3 && UNLOCKED; // R2
	assign wr_bb  = WR_STB && sel_bb && UNLOCKED; // R2

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	logic       b3_pskip_ff;
	logic [5:0] b3_code_ff;
	logic       bb_pskip_ff;
	logic [5:0] bb_code_ff;
	logic [5:0] nxt_b3_code;
	logic [5:0] nxt_bb_code;

	// strap picks the power-up code; slew and go bit play no part here
	assign nxt_b3_code = strap_load ? (strap_sync_ff ? CSR_ALT_BUCK3 : CSR_RST_BUCK3[5:0]) // R6
		: wr_b3 ? WDATA[5:0] : b3_code_ff; // R5 R12
	assign nxt_bb_code = strap_load ? (strap_sync_ff ? CSR_ALT_BUCKBOOST
		: CSR_RST_BUCKBOOST[5:0]) // R6
		: wr_bb ? WDATA[5:0] : bb_code_ff; // R10 R12

	// step-down three register
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			b3_pskip_ff <= CSR_RST_BUCK3[CSR_BIT_PSKIP]; // R1 R4
			b3_code_ff  <= CSR_RST_BUCK3[5:0]; // R5
		end
		else
		begin
			if (wr_b3)
				b3_pskip_ff <= WDATA[CSR_BIT_PSKIP]; // R4
			b3_code_ff <= nxt_b3_code;
		end
	end

	// buck-boost register
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			bb_pskip_ff <= CSR_RST_BUCKBOOST[CSR_BIT_PSKIP]; // R7 R11
			bb_code_ff  <= CSR_RST_BUCKBOOST[5:0]; // R10
		end
		else
		begin
			if (wr_bb)
				bb_pskip_ff <= WDATA[CSR_BIT_PSKIP]; // R11
			bb_code_ff <= nxt_bb_code;
		end
	end

	// ------------------------------------------------------------------------
	// readback, bit 6 always zero
	// ------------------------------------------------------------------------
	logic [7:0] rd_mux;
	logic [7:0] rdata_ff;
	logic       rd_hit_ff;
	logic       wr_done_ff;
	assign rd_mux = sel_b3 ? {b3_pskip_ff, 1'b0, b3_code_ff} // R13
		: sel_bb ? {bb_pskip_ff, 1'b0, bb_code_ff} : 8'h00; // R11 R13

	// read data and status flops
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			rdata_ff   <= 8'h00;
			rd_hit_ff  <= 1'b0;
			wr_done_ff <= 1'b0;
		end
		else
		begin
			if (RD_STB)
				rdata_ff <= rd_mux;
			rd_hit_ff  <= RD_STB && (sel_b3 || sel_bb);
			wr_done_ff <= wr_b3 || wr_bb;
		end
	end
	assign RDATA   = rdata_ff;
	assign RD_HIT  = rd_hit_ff;
	assign WR_DONE = wr_done_ff;

	// ------------------------------------------------------------------------
	// outputs and monitor blanking
	// ------------------------------------------------------------------------
	assign BUCK3_PULSE_SKIP_ENABLE     = b3_pskip_ff; // R4
	assign BUCK3_VOLTAGE_CODE          = b3_code_ff;
	assign BUCKBOOST_PULSE_SKIP_ENABLE = bb_pskip_ff;
	assign BUCKBOOST_VOLTAGE_CODE      = bb_code_ff;

	csr_blank_timer #(.COUNT(BLANK_CYCLES)) u_blank_b3 (
		.clk   (CLOCK),
		.rst_n (RSTN),
		.start (wr_b3), // R3
		.blank (BUCK3_MON_BLANK)
	);
	csr_blank_timer #(.COUNT(BLANK_CYCLES)) u_blank_bb (
		.clk   (CLOCK),
		.rst_n (RSTN),
		.start (wr_bb), // R3
		.blank (BUCKBOOST_MON_BLANK)
	);

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	sequence locked_write_s;
		WR_STB && (sel_b3 || sel_bb) && !UNLOCKED;
	endsequence
	locked_write_kept_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R2
		(locked_write_s and !strap_load) |=> $stable(b3_code_ff) && $stable(bb_code_ff)
			&& $stable(b3_pskip_ff) && $stable(bb_pskip_ff))
		else $error("locked write changed a register");
	b3_write_lands_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R5
		wr_b3 && !strap_load |=> b3_code_ff == $past(WDATA[5:0]) && BUCK3_MON_BLANK)
		else $error("step-down write did not land");
	bb_write_lands_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R11
		wr_bb && !strap_load |=> bb_pskip_ff == $past(WDATA[7]) && BUCKBOOST_MON_BLANK)
		else $error("buck-boost write did not land");
	rsvd_bit_zero_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R13
		RD_STB |=> RDATA[CSR_BIT_RSVD] == 1'b0)
		else $error("reserved bit read as one");
	read_b3_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R1
		RD_STB && sel_b3 |=> RD_HIT && RDATA == {$past(b3_pskip_ff), 1'b0, $past(b3_code_ff)})
		else $error("step-down readback wrong");
	strap_default_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R6
		strap_load |=> b3_code_ff == ($past(strap_sync_ff) ? CSR_ALT_BUCK3 : CSR_RST_BUCK3[5:0])
			&& bb_code_ff == ($past(strap_sync_ff) ? CSR_ALT_BUCKBOOST
			: CSR_RST_BUCKBOOST[5:0]))
		else $error("strap default not applied");
	pskip_reset_a: assert property (@(posedge CLOCK) // R4
		!RSTN |=> BUCK3_PULSE_SKIP_ENABLE && BUCKBOOST_PULSE_SKIP_ENABLE)
		else $error("pulse skip did not reset to one");
	no_write_no_blank_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R3
		$rose(BUCKBOOST_MON_BLANK) |-> $past(wr_bb))
		else $error("blanking without a write");
	read_bb_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R11
		RD_STB && sel_bb |=> RD_HIT && RDATA == {$past(bb_pskip_ff), 1'b0, $past(bb_code_ff)})
		else $error("buck-boost readback wrong");
	done_needs_unlock_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // R2
		WR_DONE |-> $past(WR_STB && UNLOCKED && (sel_b3 || sel_bb)))
		else $error("write answered without unlock");
endmodule

// [hdl/csr_pkg.sv]
// ----------------------------------------------------------------------------
// constants for the converter setpoint register bank
// ----------------------------------------------------------------------------
// assumes a 25 MHz register clock and a serial-bus engine that presents
// decoded subaddress, data and write/read strobes on the same clock.
//
// How it works
// R1 - the step-down converter three register sits at subaddress 0x18 and resets to 0xbd.
// R2 - a write to either register only lands once the password unlock has been completed.
// R3 - every accepted write blanks that converter's over and under voltage monitor for 5 ms.
// R4 - bit 7 enables pulse skipping, resets to one, and zero forces fixed-frequency switching.
// R5 - bits 5-0 hold the step-down voltage code, reset 3dh, stepping 25 mV then 50 mV.
// R6 - the power-up voltage code of the step-down converter follows the default select strap; the buck-boost code powers up at 14h for either strap level.
// R7 - the buck-boost register sits at subaddress 0x19 and resets to 0x94.
// R8 - the host never writes a reserved code into the buck-boost voltage field.
// R9 - the host should change the buck-boost voltage code only while that converter is off.
// R10 - buck-boost bits 5-0 hold a code resetting to 14h, with codes 35h to 3fh reserved.
// R11 - the buck-boost register has the same pulse-skip bit 7 and a read-only zero bit 6.
// R12 - slew control and the go-bit transition do not govern these two converters.
// R13 - bit 6 of each register reads zero and ignores writes.
package csr_pkg;
	localparam logic [7:0] CSR_ADDR_BUCK3     = 8'h18;
	localparam logic [7:0] CSR_ADDR_BUCKBOOST = 8'h19;
	localparam logic [7:0] CSR_RST_BUCK3      = 8'hbd;
	localparam logic [7:0] CSR_RST_BUCKBOOST  = 8'h94;
	localparam int         CSR_BIT_PSKIP      = 7;
	localparam int         CSR_BIT_RSVD       = 6;
	localparam int         CSR_CODE_W         = 6;
	localparam logic [5:0] CSR_CODE_MAX_BB    = 6'h34;
	// alternate power-up codes when the strap is high, arbitrary defaults
	localparam logic [5:0] CSR_ALT_BUCK3      = 6'h0c;
	localparam logic [5:0] CSR_ALT_BUCKBOOST  = 6'h14;
	// blanking time and its cycle count at 25 MHz
	localparam int         CSR_CLK_HZ         = 25000000;
	localparam int         CSR_BLANK_US       = 5000;
	localparam int         CSR_BLANK_CYC      = CSR_CLK_HZ / 1000000 * CSR_BLANK_US;
endpackage

// [hdl/csr_blank_timer.sv]
// ----------------------------------------------------------------------------
// monitor blanking timer for one converter
// ----------------------------------------------------------------------------
// assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module csr_blank_timer
	import csr_pkg::*;
#(
	parameter int COUNT = CSR_BLANK_CYC
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	input  wire logic start,
	output logic      blank
);
	localparam int CW = $clog2(COUNT + 1);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	// restart on every write, else count down to zero
	assign nxt_cnt = start ? CW'(COUNT) : (cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff; // R3
	assign blank   = (cnt_ff != '0);

	// counter register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	blank_starts_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
		start |=> blank && cnt_ff == CW'(COUNT))
		else $error("blanking did not start at full count");
	blank_counts_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
		blank && !start |=> cnt_ff == $past(cnt_ff) - CW'(1))
		else $error("blanking counter did not step down");
endmodule

// [tb/csr_host.sv]
// host model: register writes, reads and the unlock level
// assumes the bank samples strobes on the rising clock edge
`timescale 1ns/100ps
module csr_host (
	// clock of the bank
	input  wire logic  clk,
	// access side, driven by the tasks below
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic       wr_stb,
	output logic       rd_stb,
	output logic       unlocked
);
	// ----------------------------------------------------------------
	// bus signals, released address and data lines show the inverse of their last value
	// ----------------------------------------------------------------
	initial
	begin
		addr     = 8'h00;
		wdata    = 8'h00;
		wr_stb   = 1'b0;
		rd_stb   = 1'b0;
		unlocked = 1'b0;
	end
	// unlock level, held between accesses
	task automatic set_unlock(input logic v);
		unlocked = v;
	endtask
	// one access, driven just after an edge and held over the next edge
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr_stb = w;
		rd_stb = ~w;
		@(posedge clk);
		#1;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
endmodule

// [tb/csr_regs_test.sv]
// self-checking bench of the converter setpoint register bank
// assumes csr_host drives the access side and a short blanking count
`timescale 1ns/100ps
module csr_regs_test;
	import csr_pkg::*;
	// ----------------------------------------------------------------
	// bench settings and signals
	// ----------------------------------------------------------------
	localparam int          BLANK        = 20;
	// the whole run needs about 250 cycles; sixteen times that before giving up
	localparam int          WATCHDOG_CYC = 4000;
	localparam logic [15:0] LFSR_SEED    = 16'h11f9;
	logic        clock;
	logic        rstn = 1'b0;
	logic        strap = 1'b0;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr_stb;
	logic        rd_stb;
	logic        unlocked;
	logic [7:0]  rdata;
	logic        rd_hit;
	logic        wr_done;
	logic        b3_ps;
	logic        bb_ps;
	logic        b3_bl;
	logic        bb_bl;
	logic [5:0]  b3_code;
	logic [5:0]  bb_code;
	logic [7:0]  exp_q[$];
	int          mismatches = 0;
	int          checked = 0;
	int          done_cnt = 0;
	int          exp_done = 0;
	logic [15:0] rnd = LFSR_SEED;
	logic [7:0]  d;

	// ----------------------------------------------------------------
	// host model and bank
	// ----------------------------------------------------------------
	csr_host i_host (
		.clk      (clock),
		.addr     (addr),
		.wdata    (wdata),
		.wr_stb   (wr_stb),
		.rd_stb   (rd_stb),
		.unlocked (unlocked)
	);
	csr_regs #(.BLANK_CYCLES(BLANK)) i_dut (
		.CLOCK                       (clock),
		.RSTN                        (rstn),
		.ADDR                        (addr),
		.WDATA                       (wdata),
		.WR_STB                      (wr_stb),
		.RD_STB                      (rd_stb),
		.UNLOCKED                    (unlocked),
		.RDATA                       (rdata),
		.RD_HIT                      (rd_hit),
		.WR_DONE                     (wr_done),
		.DEFAULT_SELECT_STRAP        (strap),
		.BUCK3_PULSE_SKIP_ENABLE     (b3_ps),
		.BUCK3_VOLTAGE_CODE          (b3_code),
		.BUCK3_MON_BLANK             (b3_bl),
		.BUCKBOOST_PULSE_SKIP_ENABLE (bb_ps),
		.BUCKBOOST_VOLTAGE_CODE      (bb_code),
		.BUCKBOOST_MON_BLANK         (bb_bl)
	);
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// stimulus source and compare tasks
	// ----------------------------------------------------------------
	// next value of the stimulus shift register
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// oldest read note, unknown when none is left so that a stray hit fails
	function automatic logic [7:0] pop_note();
		if (exp_q.size() == 0)
			return 8'hxx;
		return exp_q.pop_front();
	endfunction
	// common core: counts and reports one result
	task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// read data
	task automatic check_read(input logic [7:0] exp);
		compare(rdata, exp, "read data");
	endtask
	// step-down pins as a register image
	task automatic check_b3(input logic [7:0] exp);
		compare({b3_ps, 1'b0, b3_code}, exp, "step-down pins");
	endtask
	// buck-boost pins as a register image
	task automatic check_bb(input logic [7:0] exp);
		compare({bb_ps, 1'b0, bb_code}, exp, "buck-boost pins");
	endtask
	// both blanking outputs
	task automatic check_blank(input logic b3, input logic bb);
		compare({6'h00, b3_bl, bb_bl}, {6'h00, b3, bb}, "blanking");
	endtask
	// event counts
	task automatic check_count(input int got, input int exp, input string what);
		compare(got[7:0], exp[7:0], what);
	endtask
	// watcher: read answers take the oldest note, write answers are counted
	always @(negedge clock)
	begin
		if (rd_hit === 1'b1)
			check_read(pop_note());
		if (wr_done === 1'b1)
			done_cnt++;
	end
	// read one register and note the byte the rules expect
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.access(1'b0, a, 8'h00);
	endtask
	// write one register; mapped writes while unlocked must answer
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		if (unlocked && (a == CSR_ADDR_BUCK3 || a == CSR_ADDR_BUCKBOOST))
			exp_done++;
		i_host.access(1'b1, a, v);
	endtask
	// reset with a strap level, released just after an edge
	task automatic do_reset(input logic s);
		rstn = 1'b0;
		strap = s;
		repeat (16) @(posedge clock);
		#1;
		rstn = 1'b1;
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog and scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (WATCHDOG_CYC) @(posedge clock);
		mismatches++;
		$display("wrong value at %0t: watchdog expired", $time);
		report_and_stop();
	end
	initial
	begin
		// reset values, then locked writes that must not land
		do_reset(1'b0);
		rd(CSR_ADDR_BUCK3, CSR_RST_BUCK3);
		rd(CSR_ADDR_BUCKBOOST, CSR_RST_BUCKBOOST);
		check_b3(CSR_RST_BUCK3);
		check_bb({2'h2, 6'h14});
		wr(CSR_ADDR_BUCK3, 8'h41);
		wr(CSR_ADDR_BUCKBOOST, 8'h41);
		rd(CSR_ADDR_BUCK3, CSR_RST_BUCK3);
		rd(CSR_ADDR_BUCKBOOST, CSR_RST_BUCKBOOST);
		check_blank(1'b0, 1'b0);
		$display("reset and lock test done");
		// random writes while unlocked; bit 6 must read back as zero
		i_host.set_unlock(1'b1);
		for (int i = 0; i < 8; i++)
		begin
			rnd = lfsr_next(rnd);
			d = rnd[7:0];
			wr(CSR_ADDR_BUCK3, d);
			rd(CSR_ADDR_BUCK3, d & 8'hbf);
			check_b3(d & 8'hbf);
			d[5:0] = rnd[13:8] % (CSR_CODE_MAX_BB + 6'h01);
			wr(CSR_ADDR_BUCKBOOST, d);
			rd(CSR_ADDR_BUCKBOOST, d & 8'hbf);
			check_bb(d & 8'hbf);
		end
		// unmapped subaddresses: write ignored, read gives zero and no hit
		wr(8'h20, 8'h55);
		i_host.access(1'b0, 8'h21, 8'h00);
		check_read(8'h00);
		rd(CSR_ADDR_BUCKBOOST, d & 8'hbf);
		$display("write and read test done");
		// blanking of each converter alone, full length
		for (int k = 0; k < 2; k++)
		begin
			repeat (BLANK + 2) @(posedge clock);
			wr(k ? CSR_ADDR_BUCKBOOST : CSR_ADDR_BUCK3, 8'h10);
			check_blank(k == 0, k == 1);
			repeat (BLANK - 1) @(posedge clock);
			#1;
			check_blank(k == 0, k == 1);
			@(posedge clock);
			#1;
			check_blank(1'b0, 1'b0);
		end
		// a rewrite during blanking restarts the full count
		wr(CSR_ADDR_BUCKBOOST, 8'h10);
		repeat (BLANK / 2) @(posedge clock);
		wr(CSR_ADDR_BUCKBOOST, 8'h12);
		repeat (BLANK - 1) @(posedge clock);
		#1;
		check_blank(1'b0, 1'b1);
		@(posedge clock);
		#1;
		check_blank(1'b0, 1'b0);
		check_bb(8'h12);
		check_count(done_cnt, exp_done, "write answers");
		$display("blanking test done");
		// strap high picks the alternate power-up codes
		do_reset(1'b1);
		check_b3({2'h2, CSR_ALT_BUCK3});
		rd(CSR_ADDR_BUCK3, {2'h2, CSR_ALT_BUCK3});
		rd(CSR_ADDR_BUCKBOOST, {2'h2, CSR_ALT_BUCKBOOST});
		repeat (2) @(posedge clock);
		check_count(exp_q.size(), 0, "notes left over");
		$display("strap test done");
		report_and_stop();
	end
endmodule
